// ==== inc/fma_pkg.sv ====
// Shared constants and types for the FP32 multiply-add slice.
// Assumes a 32-bit AXI4-Lite register port and IEEE single format.
`default_nettype none
package fma_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] RESULT_ADDR = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // --------------------------------------------------------------
    // Number format
    // --------------------------------------------------------------
    localparam logic [31:0] QNAN = 32'h7FC00000;
    localparam logic [30:0] INF_MAG = 31'h7F800000;
    localparam logic [7:0] EXP_SPECIAL = 8'hFF;
    localparam logic signed [9:0] EXP_BIAS = 10'sh07F;
    localparam logic signed [9:0] EXP_OVF = 10'sh0FF;
    localparam logic signed [9:0] EXP_ONE = 10'sh001;
    localparam logic [7:0] ALIGN_LIMIT = 8'h1B;
    localparam int NORM_STEPS = 26;
    // Slice configuration
    typedef enum logic [1:0] {
        FMA_MODE_MAC = 2'h0,
        FMA_MODE_VEC1 = 2'h1,
        FMA_MODE_VEC2 = 2'h2
    } fma_mode_t;
    // Rounded value with its four exception flags
    typedef struct packed {
        logic [31:0] val;
        logic of;
        logic uf;
        logic nx;
        logic nv;
    } fma_res_t;
endpackage
`default_nettype wire

// ==== rtl/fma_vector_slice.sv ====
// FP32 multiply-accumulate / vector slice with AXI4-Lite control.
// Assumes fabric drives operands, enables and clears on aclk.
//
// Contract
// - Accumulate high feeds adder output back in MAC mode
// - Accumulate control registered with the operands on ena[0]
// - Two 32-bit multiplier operand buses
// - VEC1 mode takes 32-bit adder operand
// - Result on 32-bit output bus
// - Cascade output drives next slice
// - VEC2 mode takes 32-bit cascade input
// - All registers on one clock
// - Three active-high clock enables
// - Two clears, async or sync by parameter
// - Product overflow gives infinity and flag
// - Product underflow flushes zero, flags
// - Product inexact when rounded or out-of-range
// - Invalid product gives quiet NaN, flag
// - Sum overflow gives infinity and flag
// - Sum underflow flushes zero, flags
// - Sum inexact when rounded or out-of-range
// - Invalid sum gives quiet NaN, flag
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fma_vector_slice #(
    parameter bit CLEAR_ASYNC = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] ena,
    input wire logic [1:0] clr,
    input wire logic accumulate,
    input wire logic [31:0] product_operand_x,
    input wire logic [31:0] product_operand_y,
    input wire logic [31:0] sum_operand_in,
    input wire logic [31:0] cascade_in,
    output logic [31:0] single_result_out,
    output logic [31:0] cascade_out,
    output logic product_too_large_flag,
    output logic product_too_small_flag,
    output logic product_rounded_flag,
    output logic product_nan_flag,
    output logic sum_too_large_flag,
    output logic sum_too_small_flag,
    output logic sum_rounded_flag,
    output logic sum_nan_flag,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // --------------------------------------------------------------
    // Arithmetic helpers
    // --------------------------------------------------------------

    // Round to nearest even, then range check and pack
    function automatic fma_pkg::fma_res_t fp_round(
        input logic sgn,
        input logic signed [9:0] exp_in,
        input logic [26:0] sig
    );
        logic up;
        logic [24:0] man;
        logic signed [9:0] e;
        fma_pkg::fma_res_t r;
        r = '0;
        e = exp_in;
        up = sig[2] & (sig[1] | sig[0] | sig[3]);
        man = {1'b0, sig[26:3]} + {24'h000000, up};
        // Mantissa carry out bumps the exponent
        if (man[24]) begin
            man = man >> 1;
            e = e + fma_pkg::EXP_ONE;
        end
        r.nx = |sig[2:0];
        if (e >= fma_pkg::EXP_OVF) begin
            r.val = {sgn, fma_pkg::INF_MAG};
            r.of = 1'b1;
            r.nx = 1'b1;
        end else if (e < fma_pkg::EXP_ONE) begin
            // No subnormals: flush keeps the sign
            r.val = {sgn, 31'h00000000};
            r.uf = 1'b1;
            r.nx = 1'b1;
        end else begin
            r.val = {sgn, e[7:0], man[22:0]};
        end
        return r;
    endfunction

    // Single precision product, subnormal inputs read as zero
    function automatic fma_pkg::fma_res_t fp_mul(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic za, zb, ia, ib, na, nb, sgn;
        logic [47:0] p;
        logic [26:0] sig;
        logic signed [9:0] e;
        fma_pkg::fma_res_t r;
        r = '0;
        za = (a[30:23] == 8'h00);
        zb = (b[30:23] == 8'h00);
        ia = (a[30:23] == fma_pkg::EXP_SPECIAL) && (a[22:0] == 23'h000000);
        ib = (b[30:23] == fma_pkg::EXP_SPECIAL) && (b[22:0] == 23'h000000);
        na = (a[30:23] == fma_pkg::EXP_SPECIAL) && !ia;
        nb = (b[30:23] == fma_pkg::EXP_SPECIAL) && !ib;
        sgn = a[31] ^ b[31];
        if (na || nb || (ia && zb) || (ib && za)) begin
            r.val = fma_pkg::QNAN;
            r.nv = 1'b1;
        end else if (ia || ib) begin
            r.val = {sgn, fma_pkg::INF_MAG};
        end else if (za || zb) begin
            r.val = {sgn, 31'h00000000};
        end else begin
            p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
            e = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]})
                - fma_pkg::EXP_BIAS;
            if (p[47]) begin
                sig = {p[47:22], |p[21:0]};
                e = e + fma_pkg::EXP_ONE;
            end else begin
                sig = {p[46:21], |p[20:0]};
            end
            r = fp_round(sgn, e, sig);
        end
        return r;
    endfunction

    // Single precision sum with guard, round and sticky bits
    function automatic fma_pkg::fma_res_t fp_add(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic za, zb, ia, ib, na, nb;
        logic [31:0] big, sml;
        logic [7:0] d;
        logic [26:0] ms, lost, sh, sig;
        logic [27:0] s;
        logic signed [9:0] e;
        fma_pkg::fma_res_t r;
        r = '0;
        za = (a[30:23] == 8'h00);
        zb = (b[30:23] == 8'h00);
        ia = (a[30:23] == fma_pkg::EXP_SPECIAL) && (a[22:0] == 23'h000000);
        ib = (b[30:23] == fma_pkg::EXP_SPECIAL) && (b[22:0] == 23'h000000);
        na = (a[30:23] == fma_pkg::EXP_SPECIAL) && !ia;
        nb = (b[30:23] == fma_pkg::EXP_SPECIAL) && !ib;
        if (na || nb || (ia && ib && (a[31] != b[31]))) begin
            r.val = fma_pkg::QNAN;
            r.nv = 1'b1;
        end else if (ia) begin
            r.val = a;
        end else if (ib) begin
            r.val = b;
        end else if (za && zb) begin
            r.val = {a[31] & b[31], 31'h00000000};
        end else if (za) begin
            r.val = b;
        end else if (zb) begin
            r.val = a;
        end else begin
            // Larger magnitude sets sign and exponent
            big = (b[30:0] > a[30:0]) ? b : a;
            sml = (b[30:0] > a[30:0]) ? a : b;
            d = big[30:23] - sml[30:23];
            ms = {1'b1, sml[22:0], 3'h0};
            if (d >= fma_pkg::ALIGN_LIMIT) begin
                sh = 27'h0000001;
            end else begin
                lost = ms & ~({27{1'b1}} << d);
                sh = (ms >> d) | {26'h0000000, |lost};
            end
            if (big[31] == sml[31]) begin
                s = {2'b01, big[22:0], 3'h0} + {1'b0, sh};
            end else begin
                s = {2'b01, big[22:0], 3'h0} - {1'b0, sh};
            end
            e = $signed({2'b00, big[30:23]});
            if (s == 28'h0000000) begin
                r.val = 32'h00000000;
            end else if (s[27]) begin
                sig = {s[27:2], s[1] | s[0]};
                e = e + fma_pkg::EXP_ONE;
                r = fp_round(big[31], e, sig);
            end else begin
                sig = s[26:0];
                // Cancellation: walk the leading one up
                for (int i = 0; i < fma_pkg::NORM_STEPS; i++) begin
                    if (!sig[26]) begin
                        sig = sig << 1;
                        e = e - fma_pkg::EXP_ONE;
                    end
                end
                r = fp_round(big[31], e, sig);
            end
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Clear routing
    // --------------------------------------------------------------
    // clear type by parameter
    logic [1:0] clr_async; // Reaches the async edge only
    logic [1:0] clr_sync; // Sampled by the clock only
    assign clr_async = CLEAR_ASYNC ? clr : 2'b00;
    assign clr_sync = CLEAR_ASYNC ? 2'b00 : clr;

    // --------------------------------------------------------------
    // Register file state
    // --------------------------------------------------------------
    fma_pkg::fma_mode_t mode_q; // Slice configuration
    logic aw_hold_q; // Write address captured
    logic w_hold_q; // Write data captured
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write; // Both halves present, no response owed
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

    // --------------------------------------------------------------
    // Datapath state
    // --------------------------------------------------------------
    logic [31:0] opx_q, opy_q, addin_q; // Input bank
    logic acc_q; // Accumulate, aligned with input bank
    fma_pkg::fma_res_t prod_q; // Rounded product and its flags
    logic [31:0] addb_q; // Adder operand, aligned with product
    logic accb_q; // Accumulate, aligned with product
    logic [31:0] addend_w; // Second adder operand
    fma_pkg::fma_res_t sum_w;

    always_comb begin
        unique case (mode_q)
            fma_pkg::FMA_MODE_VEC1,
            fma_pkg::FMA_MODE_VEC2: addend_w = addb_q;
            // Idle feedback adds exact zero
            default: addend_w = accb_q ? single_result_out : 32'h00000000;
        endcase
    end
    assign sum_w = fp_add(prod_q.val, addend_w);

    // Input bank, on ena[0], cleared by clr[0]
    // single clock, enable gated
    always_ff @(posedge aclk or posedge clr_async[0]) begin
        if (clr_async[0]) begin
            opx_q <= 32'h00000000;
            opy_q <= 32'h00000000;
            addin_q <= 32'h00000000;
            acc_q <= 1'b0;
        end else if (!aresetn || clr_sync[0]) begin
            opx_q <= 32'h00000000;
            opy_q <= 32'h00000000;
            addin_q <= 32'h00000000;
            acc_q <= 1'b0;
        end else if (ena[0]) begin
            opx_q <= product_operand_x;
            opy_q <= product_operand_y;
            acc_q <= accumulate;
            addin_q <= (mode_q == fma_pkg::FMA_MODE_VEC2) ? cascade_in
                : sum_operand_in;
        end
    end

    // Product stage, on ena[1], cleared by clr[0]
    // product exceptions
    always_ff @(posedge aclk or posedge clr_async[0]) begin
        if (clr_async[0]) begin
            prod_q <= '0;
            addb_q <= 32'h00000000;
            accb_q <= 1'b0;
        end else if (!aresetn || clr_sync[0]) begin
            prod_q <= '0;
            addb_q <= 32'h00000000;
            accb_q <= 1'b0;
        end else if (ena[1]) begin
            prod_q <= fp_mul(opx_q, opy_q);
            addb_q <= addin_q;
            accb_q <= acc_q;
        end
    end

    // Output stage, on ena[2], cleared by clr[1]
    // clear empties the accumulator
    always_ff @(posedge aclk or posedge clr_async[1]) begin
        if (clr_async[1]) begin
            single_result_out <= 32'h00000000;
            cascade_out <= 32'h00000000;
            {sum_too_large_flag, sum_too_small_flag} <= 2'b00;
            {sum_rounded_flag, sum_nan_flag} <= 2'b00;
            {product_too_large_flag, product_too_small_flag} <= 2'b00;
            {product_rounded_flag, product_nan_flag} <= 2'b00;
        end else if (!aresetn || clr_sync[1]) begin
            single_result_out <= 32'h00000000;
            cascade_out <= 32'h00000000;
            {sum_too_large_flag, sum_too_small_flag} <= 2'b00;
            {sum_rounded_flag, sum_nan_flag} <= 2'b00;
            {product_too_large_flag, product_too_small_flag} <= 2'b00;
            {product_rounded_flag, product_nan_flag} <= 2'b00;
        end else if (ena[2]) begin
            single_result_out <= sum_w.val;
            cascade_out <= sum_w.val;
            {sum_too_large_flag, sum_too_small_flag} <= {sum_w.of, sum_w.uf};
            {sum_rounded_flag, sum_nan_flag} <= {sum_w.nx, sum_w.nv};
            // Product flags travel with their result
            {product_too_large_flag, product_too_small_flag}
                <= {prod_q.of, prod_q.uf};
            {product_rounded_flag, product_nan_flag}
                <= {prod_q.nx, prod_q.nv};
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    // Address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Register update and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= fma_pkg::fma_mode_t'(fma_pkg::CTRL_RESET);
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fma_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == fma_pkg::CTRL_ADDR) begin
                s_axi_bresp <= fma_pkg::RESP_OKAY;
                // Only byte lane 0 carries the mode
                if (wstrb_q[0]) begin
                    mode_q <= fma_pkg::fma_mode_t'(wdata_q[1:0]);
                end
            end else if (awaddr_q == fma_pkg::STATUS_ADDR ||
                         awaddr_q == fma_pkg::RESULT_ADDR) begin
                // Read-only: write ignored
                s_axi_bresp <= fma_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= fma_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    // Data is captured at the address edge, so it is a snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= fma_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= fma_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                fma_pkg::CTRL_ADDR: s_axi_rdata <= {30'h00000000, mode_q};
                fma_pkg::STATUS_ADDR: s_axi_rdata <= {24'h000000,
                    product_too_large_flag, product_too_small_flag,
                    product_rounded_flag, product_nan_flag,
                    sum_too_large_flag, sum_too_small_flag,
                    sum_rounded_flag, sum_nan_flag};
                fma_pkg::RESULT_ADDR: s_axi_rdata <= single_result_out;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= fma_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Result and the sum overflow flag both back at zero
    sequence s_cleared;
        (single_result_out == 32'h00000000) && !sum_too_large_flag;
    endsequence

    AST_CLR_ACC: assert property (clr[1] |=> s_cleared)
        else $error("clear did not empty the accumulator");
    AST_ENA_HOLD: assert property (
        !ena[2] && !clr[1] |=> $stable(single_result_out))
        else $error("result moved with its enable low");
    // Sampled reset term: the release edge itself still loads zeros
    AST_ACC_SAMPLE: assert property (
        aresetn && ena[0] && !clr[0] |=> acc_q == $past(accumulate))
        else $error("accumulate not sampled");
    AST_ACC_FEED: assert property (
        ena[2] && !clr[1] && mode_q == fma_pkg::FMA_MODE_MAC && !accb_q
        && prod_q.val[30:0] != 31'h00000000
        |=> single_result_out == $past(prod_q.val))
        else $error("feedback not disabled");
    AST_VEC2_SRC: assert property (
        aresetn && ena[0] && !clr[0] && mode_q == fma_pkg::FMA_MODE_VEC2
        |=> addin_q == $past(cascade_in))
        else $error("cascade input not taken");
    AST_CASCADE: assert property (
        cascade_out == single_result_out)
        else $error("cascade output differs from result");
    AST_PROD_OVF: assert property (prod_q.of |->
        prod_q.val[30:0] == fma_pkg::INF_MAG && prod_q.nx)
        else $error("product overflow not infinite");
    AST_PROD_UNF: assert property (prod_q.uf |->
        prod_q.val[30:0] == 31'h00000000 && prod_q.nx)
        else $error("product underflow not flushed");
    AST_PROD_NAN: assert property (
        prod_q.nv |-> prod_q.val == fma_pkg::QNAN && !prod_q.of)
        else $error("invalid product not quiet NaN");
    AST_SUM_OVF: assert property (ena[2] && !clr[1] && sum_w.of
        |=> sum_too_large_flag &&
        single_result_out[30:0] == fma_pkg::INF_MAG)
        else $error("sum overflow not infinite");
    AST_SUM_UNF: assert property (sum_too_small_flag |->
        single_result_out[30:0] == 31'h00000000 && sum_rounded_flag)
        else $error("sum underflow not flushed");
    AST_SUM_NX: assert property (
        sum_too_large_flag || sum_too_small_flag |-> sum_rounded_flag)
        else $error("sum range error not inexact");
    AST_SUM_NAN: assert property (sum_nan_flag |->
        single_result_out == fma_pkg::QNAN)
        else $error("invalid sum not quiet NaN");

endmodule
`default_nettype wire

// ==== testbench/fma_prev_slice.sv ====
// Model of the preceding slice that feeds our cascade input.
// Assumes the bench loads its chain value on aclk.
`timescale 1ns/1ps
`default_nettype none
module fma_prev_slice (
    input wire logic aclk,
    input wire logic load,
    input wire logic [31:0] load_val,
    output logic [31:0] cascade_out
);
    // Registered chain value, held between loads
    // chain output register
    always_ff @(posedge aclk) begin
        if (load) begin
            cascade_out <= load_val;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fp32_mult_accumulate_vector_tb_top.sv ====
// Self-checking bench for the FP32 multiply-add slice.
// Assumes fma_pkg and the slice RTL are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fp32_mult_accumulate_vector_tb_top;
    localparam logic [31:0] f_z = 32'h00000000;
    localparam logic [31:0] f_one = 32'h3F800000;
    localparam logic [31:0] f_two = 32'h40000000;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [2:0] ena = 3'h7;
    logic [1:0] clr = 2'h0;
    logic accumulate = 1'h1;
    logic ld = 1'h1;
    logic [31:0] product_operand_x = 32'h0, product_operand_y = 32'h0;
    logic [31:0] sum_operand_in = 32'h0, cascade_in, ld_val = 32'h3F000000;
    logic [31:0] single_result_out, cascade_out, s_axi_rdata;
    logic [31:0] s_axi_wdata = 32'h0;
    logic product_too_large_flag, product_too_small_flag;
    logic product_rounded_flag, product_nan_flag;
    logic sum_too_large_flag, sum_too_small_flag;
    logic sum_rounded_flag, sum_nan_flag;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] flg;
    int mismatches = 0;
    int samples_checked = 0;
    // Flags packed in the same order as the status word
    assign flg = {product_too_large_flag, product_too_small_flag,
        product_rounded_flag, product_nan_flag, sum_too_large_flag,
        sum_too_small_flag, sum_rounded_flag, sum_nan_flag};
    always #12.5 aclk = ~aclk;
    fma_vector_slice u_fma_vector_slice (.aclk, .aresetn, .ena, .clr,
        .accumulate, .product_operand_x, .product_operand_y,
        .sum_operand_in, .cascade_in, .single_result_out, .cascade_out,
        .product_too_large_flag, .product_too_small_flag,
        .product_rounded_flag, .product_nan_flag, .sum_too_large_flag,
        .sum_too_small_flag, .sum_rounded_flag, .sum_nan_flag,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    fma_prev_slice u_fma_prev_slice (.aclk, .load(ld), .load_val(ld_val),
        .cascade_out(cascade_in));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Waits as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // One operand set for one cycle, then idle zeros with feedback on;
    // the result is looked at exactly two edges after capture
    task automatic op(input logic [31:0] a, b, sv, input logic ac,
        input logic [31:0] er, input logic [7:0] ef);
        @(posedge aclk);
        product_operand_x <= a;
        product_operand_y <= b;
        sum_operand_in <= sv;
        accumulate <= ac;
        @(posedge aclk);
        product_operand_x <= f_z;
        product_operand_y <= f_z;
        sum_operand_in <= f_z;
        accumulate <= 1'h1;
        repeat (2) @(posedge aclk);
        #1;
        chk(single_result_out, er);
        chk(cascade_out, er);
        chk({24'h0, flg}, {24'h0, ef});
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        ld <= 1'h0;
        @(posedge aclk);
        #1;
        chk(single_result_out, f_z);
        rd(fma_pkg::CTRL_ADDR, f_z, fma_pkg::RESP_OKAY);
        op(f_two, 32'h40400000, f_z, 1'h0, 32'h40C00000, 8'h00);
        op(f_one, f_one, f_z, 1'h1, 32'h40E00000, 8'h00);
        op(f_one, f_one, f_z, 1'h0, f_one, 8'h00);
        op(f_one, f_one, f_z, 1'h1, f_two, 8'h00);
        @(posedge aclk);
        ena <= 3'h3;
        op(32'h40400000, f_one, f_z, 1'h0, f_two, 8'h00);
        @(posedge aclk);
        ena <= 3'h7;
        clr <= 2'h3;
        @(posedge aclk);
        clr <= 2'h0;
        #1;
        chk(single_result_out, f_z);
        op(f_one, f_one, f_z, 1'h1, f_one, 8'h00);
        $display("test accumulate done");
        op(32'h7F000000, 32'h40800000, f_z, 1'h0, 32'h7F800000, 8'hA0);
        op(32'h0D800000, 32'h0D800000, f_z, 1'h0, f_z, 8'h60);
        op(32'h3F800001, 32'h3F800001, f_z, 1'h0, 32'h3F800002, 8'h20);
        op(32'h7F800000, f_z, f_z, 1'h0, fma_pkg::QNAN, 8'h11);
        wr(fma_pkg::STATUS_ADDR, 32'hFF, fma_pkg::RESP_OKAY);
        rd(fma_pkg::STATUS_ADDR, 32'h01, fma_pkg::RESP_OKAY);
        rd(fma_pkg::RESULT_ADDR, fma_pkg::QNAN, fma_pkg::RESP_OKAY);
        wr(4'hC, f_z, fma_pkg::RESP_SLVERR);
        rd(4'hC, f_z, fma_pkg::RESP_SLVERR);
        $display("test product flags done");
        wr(fma_pkg::CTRL_ADDR, 32'h1, fma_pkg::RESP_OKAY);
        rd(fma_pkg::CTRL_ADDR, 32'h1, fma_pkg::RESP_OKAY);
        op(f_two, f_two, f_one, 1'h0, 32'h40A00000, 8'h00);
        op(32'h7F7FFFFF, f_one, 32'h7F7FFFFF, 1'h0, 32'h7F800000, 8'h0A);
        op(32'h7F800000, f_one, 32'hFF800000, 1'h0, fma_pkg::QNAN, 8'h01);
        op(32'h00C00000, f_one, 32'h80800000, 1'h0, f_z, 8'h06);
        op(f_one, f_one, 32'h30800000, 1'h0, f_one, 8'h02);
        wr(fma_pkg::CTRL_ADDR, 32'h2, fma_pkg::RESP_OKAY);
        op(f_two, f_two, f_one, 1'h0, 32'h40900000, 8'h00);
        $display("test vector done");
        end_of_test();
    end
    // Hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
